// >>> hw/clh_deglitch.sv
`timescale 1ns/1ps
`default_nettype none
module clh_deglitch
  import clh_pkg::*;
#(
  parameter int CNT_W = 11
)(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       raw_in,
  input  wire logic [2:0] filt_us_in,
  output logic            flt_out
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_flt;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(int'(filt_us_in) * CYC_PER_US);

  always_comb
  begin
    next_cnt = cnt;
    next_flt = 1'b0;
    if (!raw_in)
    begin
      next_cnt = '0;
    end
    else if (cnt >= limit)
    begin
      next_flt = 1'b1;
    end
    else
    begin
      next_cnt = cnt + CNT_W'(1);
      next_flt = (cnt + CNT_W'(1)) >= limit;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt     <= '0;
      flt_out <= 1'b0;
    end
    else
    begin
      cnt     <= next_cnt;
      flt_out <= next_flt;
    end
  end

  drop_low_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !raw_in |=> !flt_out)
    else $error("filter output high after input dropped");

  no_filter_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (raw_in && filt_us_in == 3'h0) |=> flt_out)
    else $error("unfiltered input not passed in one cycle");

endmodule
`default_nettype wire

// >>> hw/clh_irq.sv
`timescale 1ns/1ps
`default_nettype none
module clh_irq #(
  parameter int W = 4
)(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr_wr_in,
  input  wire logic         en_wr_in,
  input  wire logic [W-1:0] wdata_in,
  output logic [W-1:0]      status_out,
  output logic [W-1:0]      enable_out,
  output logic              irq_out
);

  logic [W-1:0] next_status;
  logic [W-1:0] next_enable;
  logic         next_irq;

  always_comb
  begin
    next_status = status_out;
    next_enable = enable_out;
    if (clr_wr_in)
    begin
      next_status = next_status & ~wdata_in;
    end
    // Set wins over a clear in the same cycle
    next_status = next_status | set_in;
    if (en_wr_in)
    begin
      next_enable = wdata_in;
    end
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_out <= '0;
      enable_out <= '0;
      irq_out    <= 1'b0;
    end
    else
    begin
      status_out <= next_status;
      enable_out <= next_enable;
      irq_out    <= next_irq;
    end
  end

endmodule
`default_nettype wire

// >>> hw/clh_pkg.sv
`default_nettype none
package clh_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] WAIT_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] CLR_OFS    = 8'h0C;
  localparam logic [7:0] IEN_OFS    = 8'h10;
  localparam logic [7:0] STATE_OFS  = 8'h14;
  localparam logic [7:0] CTRL_OFS   = 8'h18;

  // Configuration field positions
  localparam int RETRY_LIM_LSB = 0;
  localparam int FILT_LSB      = 12;
  localparam int MODE_LSB      = 15;
  localparam int THR_LSB       = 19;
  localparam int NM_EN_BIT     = 28;

  // Reset values
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [15:0] WAIT_RST = 16'h03E8;

  // Status bit positions
  localparam int ST_LOCK  = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_RETRY = 2;
  localparam int ST_NOMTR = 3;
  localparam int ST_W     = 4;

  // Fixed filter for the no-motor comparison, in microseconds
  localparam logic [2:0] NM_FILT_US = 3'h7;

  // Phase current units are 0.1 mA
  localparam logic [15:0] NM_THR_TAB [8] = '{16'h01D4, 16'h01D4, 16'h0271,
                                             16'h030C, 16'h0618, 16'h0C30,
                                             16'h1248, 16'h186A};
  localparam logic [4:0] RETRY_TAB [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
                                           5'h07, 5'h0A, 5'h0F, 5'h14};

  typedef enum logic [1:0] {
    CLH_GATE_RUN,
    CLH_GATE_TRI,
    CLH_GATE_HS,
    CLH_GATE_LS
  } clh_gate_e;

  typedef enum logic [1:0] {
    CLH_RUN,
    CLH_WAIT,
    CLH_LATCH
  } clh_state_e;

  typedef struct packed {
    logic       nm_en;
    logic [2:0] nm_thr;
    logic [3:0] mode;
    logic [2:0] filt;
    logic [2:0] retry_lim;
  } clh_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } clh_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } clh_apb_rsp_s;

endpackage
`default_nettype wire

// >>> hw/clh_top.sv
// Functional notes
// - Three-bit code picks no-motor threshold, 0.0468 A to 0.625 A.
// - Response codes 0 and 1 latch the fault and tristate the gates.
// - Response code 2 latches the fault and turns on all high sides.
// - Response code 3 latches the fault and turns on all low sides.
// - Codes 4 to 7 clear the fault after the retry wait and rerun.
// - Retries are counted; beyond the limit the fault latches until software releases it.
// - Retry faulted stage: tristate for 4 and 5, high 6, low 7.
// - Codes 8 to 15 disable detection; no fault, outputs untouched.
// - Deglitch field: zero is unfiltered, 1 to 7 are microseconds.
// - A latched fault drives the active-low fault pin low.
// - Retry limit codes: 0 unlimited, then 2,3,5,7,10,15,20.
// - No-motor check works only while its enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module clh_top
  import clh_pkg::*;
#(
  parameter int WAIT_W = 16
)(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire clh_apb_req_s  apb_in,
  input  wire logic          current_limit_trip_in,
  input  wire logic          motor_driven_in,
  input  wire logic [15:0]   phase_current_in,
  output clh_apb_rsp_s       apb_out,
  output clh_gate_e          gate_mode_out,
  output logic               fault_indicator_low_out,
  output logic               retry_run_out,
  output logic               no_motor_lock_out,
  output logic               irq_out
);

  clh_cfg_s          cfg;
  logic [31:0]       cfg_word;
  logic [31:0]       next_cfg_word;
  logic [WAIT_W-1:0] lock_retry_wait;
  logic [WAIT_W-1:0] next_lock_retry_wait;
  clh_apb_rsp_s      next_apb;
  logic              wr_take;
  logic              clr_wr;
  logic              ien_wr;
  logic              sw_unlatch;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   irq_en;
  logic [ST_W-1:0]   ev_set;

  clh_state_e        state;
  clh_state_e        next_state;
  logic [3:0]        fault_mode;
  logic [3:0]        next_fault_mode;
  logic [4:0]        retry_cnt;
  logic [4:0]        next_retry_cnt;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait_cnt;
  logic [7:0]        div_cnt;
  logic [7:0]        next_div_cnt;
  logic              us_tick;
  logic              next_us_tick;
  logic              trip_flt;
  logic              trip_flt_d;
  logic              detect;
  logic              wait_done;
  logic [4:0]        retry_lim;
  logic              nm_raw;
  logic              nm_flt;
  clh_gate_e         next_gate;
  logic              next_retry_run;
  logic              ev_latch;
  logic              ev_retry;

  assign cfg.retry_lim = cfg_word[RETRY_LIM_LSB +: 3];
  assign cfg.filt      = cfg_word[FILT_LSB +: 3];
  assign cfg.mode      = cfg_word[MODE_LSB +: 4];
  assign cfg.nm_thr    = cfg_word[THR_LSB +: 3];
  assign cfg.nm_en     = cfg_word[NM_EN_BIT];

  // APB slave, one wait state so read data comes from a register
  assign wr_take    = apb_in.psel && apb_in.penable && apb_out.pready &&
                      apb_in.pwrite;
  assign clr_wr     = wr_take && apb_in.paddr == CLR_OFS;
  assign ien_wr     = wr_take && apb_in.paddr == IEN_OFS;
  assign sw_unlatch = wr_take && apb_in.paddr == CTRL_OFS &&
                      apb_in.pwdata[0];

  always_comb
  begin
    next_cfg_word        = cfg_word;
    next_lock_retry_wait = lock_retry_wait;
    next_apb             = '0;
    if (wr_take && apb_in.paddr == CFG_OFS)
    begin
      next_cfg_word = apb_in.pwdata & 32'h103F_F007;
    end
    if (wr_take && apb_in.paddr == WAIT_OFS)
    begin
      next_lock_retry_wait = apb_in.pwdata[WAIT_W-1:0];
    end
    if (apb_in.psel && apb_in.penable && !apb_out.pready)
    begin
      next_apb.pready = 1'b1;
      unique case (apb_in.paddr)
        CFG_OFS:   next_apb.prdata = cfg_word;
        WAIT_OFS:  next_apb.prdata = 32'(lock_retry_wait);
        STAT_OFS:  next_apb.prdata = 32'(status);
        CLR_OFS:   next_apb.prdata = 32'h0000_0000;
        IEN_OFS:   next_apb.prdata = 32'(irq_en);
        STATE_OFS: next_apb.prdata = {20'h00000, 3'(retry_cnt),
                                      2'(gate_mode_out), 5'(retry_cnt),
                                      2'(state)};
        CTRL_OFS:  next_apb.prdata = 32'h0000_0000;
        default:   next_apb.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_word        <= CFG_RST;
      lock_retry_wait <= WAIT_W'(WAIT_RST);
      apb_out         <= '0;
    end
    else
    begin
      cfg_word        <= next_cfg_word;
      lock_retry_wait <= next_lock_retry_wait;
      apb_out         <= next_apb;
    end
  end

  clh_deglitch u_trip_filter (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (current_limit_trip_in),
    .filt_us_in (cfg.filt),
    .flt_out    (trip_flt)
  );

  // A disabled check, an undriven motor or adequate current clears the comparison
  assign nm_raw = cfg.nm_en && motor_driven_in &&
                  phase_current_in < NM_THR_TAB[cfg.nm_thr];

  clh_deglitch u_nm_filter (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (nm_raw),
    .filt_us_in (NM_FILT_US),
    .flt_out    (nm_flt)
  );

  assign detect    = trip_flt && !trip_flt_d && !cfg.mode[3];
  assign retry_lim = RETRY_TAB[cfg.retry_lim];
  assign wait_done = state == CLH_WAIT && us_tick &&
                     wait_cnt >= lock_retry_wait;

  always_comb
  begin
    next_state      = state;
    next_fault_mode = fault_mode;
    next_retry_cnt  = retry_cnt;
    next_wait_cnt   = wait_cnt;
    next_retry_run  = 1'b0;
    ev_latch        = 1'b0;
    ev_retry        = 1'b0;
    next_div_cnt    = div_cnt + 8'h01;
    next_us_tick    = 1'b0;
    if (div_cnt == 8'(CYC_PER_US - 1))
    begin
      next_div_cnt = 8'h00;
      next_us_tick = 1'b1;
    end
    unique case (state)
      CLH_RUN:
      begin
        if (detect)
        begin
          next_fault_mode = cfg.mode;
          if (!cfg.mode[2])
          begin
            next_state = CLH_LATCH;
            ev_latch   = 1'b1;
          end
          else if (retry_lim != 5'h00 && retry_cnt >= retry_lim)
          begin
            next_state = CLH_LATCH;
            ev_latch   = 1'b1;
          end
          else
          begin
            next_state    = CLH_WAIT;
            next_wait_cnt = '0;
            ev_retry      = 1'b1;
            if (retry_cnt != 5'h1F)
            begin
              next_retry_cnt = retry_cnt + 5'h01;
            end
          end
        end
      end
      CLH_WAIT:
      begin
        if (wait_done)
        begin
          next_state     = CLH_RUN;
          next_retry_run = 1'b1;
        end
        else if (us_tick)
        begin
          next_wait_cnt = wait_cnt + WAIT_W'(1);
        end
      end
      CLH_LATCH:
      begin
        // Only software releases a latched fault
        if (sw_unlatch)
        begin
          next_state     = CLH_RUN;
          next_retry_cnt = 5'h00;
        end
      end
    endcase
    next_gate = CLH_GATE_RUN;
    if (next_state != CLH_RUN)
    begin
      unique case (next_fault_mode[1:0])
        2'h2:    next_gate = CLH_GATE_HS;
        2'h3:    next_gate = CLH_GATE_LS;
        default: next_gate = CLH_GATE_TRI;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state                   <= CLH_RUN;
      fault_mode              <= 4'h0;
      retry_cnt               <= 5'h00;
      wait_cnt                <= '0;
      div_cnt                 <= 8'h00;
      us_tick                 <= 1'b0;
      trip_flt_d              <= 1'b0;
      gate_mode_out           <= CLH_GATE_RUN;
      fault_indicator_low_out <= 1'b1;
      retry_run_out           <= 1'b0;
      no_motor_lock_out       <= 1'b0;
    end
    else
    begin
      state                   <= next_state;
      fault_mode              <= next_fault_mode;
      retry_cnt               <= next_retry_cnt;
      wait_cnt                <= next_wait_cnt;
      div_cnt                 <= next_div_cnt;
      us_tick                 <= next_us_tick;
      trip_flt_d              <= trip_flt;
      gate_mode_out           <= next_gate;
      fault_indicator_low_out <= next_state != CLH_LATCH;
      retry_run_out           <= next_retry_run;
      no_motor_lock_out       <= nm_flt;
    end
  end

  assign ev_set = {nm_flt && !no_motor_lock_out, ev_retry, ev_latch,
                   detect};

  clh_irq #(
    .W (ST_W)
  ) u_irq (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .set_in     (ev_set),
    .clr_wr_in  (clr_wr),
    .en_wr_in   (ien_wr),
    .wdata_in   (apb_in.pwdata[ST_W-1:0]),
    .status_out (status),
    .enable_out (irq_en),
    .irq_out    (irq_out)
  );

  sequence retry_entry_s;
    // A zero wait may end on the very next tick
    state == CLH_RUN && detect && cfg.mode[2] && lock_retry_wait != '0 &&
      (retry_lim == 5'h00 || retry_cnt < retry_lim);
  endsequence

  sequence wait_end_s;
    state == CLH_WAIT && wait_done;
  endsequence

  latch_pin_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == CLH_LATCH |-> !fault_indicator_low_out)
    else $error("fault pin not low while latched");

  tri_latch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_RUN && detect && cfg.mode[3:1] == 3'h0) |=>
      state == CLH_LATCH && gate_mode_out == CLH_GATE_TRI)
    else $error("codes 0 and 1 did not latch tristated");

  hs_brake_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_RUN && detect && cfg.mode == 4'h2) |=>
      state == CLH_LATCH && gate_mode_out == CLH_GATE_HS)
    else $error("code 2 did not latch high side brake");

  ls_brake_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_RUN && detect && cfg.mode == 4'h3) |=>
      state == CLH_LATCH && gate_mode_out == CLH_GATE_LS)
    else $error("code 3 did not latch low side brake");

  retry_cycle_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    retry_entry_s |=> state == CLH_WAIT ##0 (state == CLH_WAIT)[*2])
    else $error("retry wait not entered");

  retry_rerun_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wait_end_s |=> retry_run_out && state == CLH_RUN ##1 !retry_run_out)
    else $error("no single rerun pulse after retry wait");

  retry_limit_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_RUN && detect && cfg.mode[2] && retry_lim != 5'h00 &&
     retry_cnt >= retry_lim) |=> state == CLH_LATCH)
    else $error("retry limit exceeded without latching");

  retry_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_WAIT && fault_mode == 4'h6) |->
      gate_mode_out == CLH_GATE_HS)
    else $error("code 6 retry wait not in high side brake");

  disabled_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == CLH_RUN && cfg.mode[3]) |=>
      state == CLH_RUN && gate_mode_out == CLH_GATE_RUN)
    else $error("disabled detection still faulted");

  nm_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!cfg.nm_en)[*2] |=> !no_motor_lock_out)
    else $error("no-motor lock while check disabled");

endmodule
`default_nettype wire

// >>> verif/clh_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module clh_power_stage
  import clh_pkg::*;
(
  input  wire logic        jam_in,
  input  wire logic        drive_in,
  input  wire logic [15:0] load_in,
  input  wire clh_gate_e   gate_mode_in,
  output logic             trip_out,
  output logic             driven_out,
  output logic [15:0]      current_out
);
  // Overcurrent needs a commutating bridge; a brake or an open bridge
  // stops it, so a jammed rotor trips again only once run is handed back
  assign driven_out  = drive_in && (gate_mode_in == CLH_GATE_RUN);
  assign trip_out    = jam_in && (gate_mode_in == CLH_GATE_RUN);
  // No sensed current while the bridge is not commutating
  assign current_out = driven_out ? load_in : 16'h0000;
endmodule
`default_nettype wire

// >>> verif/current_limit_lock_fault_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module current_limit_lock_fault_handler_tb
  import clh_pkg::*;
;
  typedef struct packed {
    logic [3:0] mode;
    clh_gate_e  gate;
    logic       pin;
    logic       retry;
  } clh_tb_row_s;

  localparam clh_tb_row_s ROWS [16] = '{
    '{4'h0, CLH_GATE_TRI, 1'b0, 1'b0}, '{4'h1, CLH_GATE_TRI, 1'b0, 1'b0},
    '{4'h2, CLH_GATE_HS, 1'b0, 1'b0}, '{4'h3, CLH_GATE_LS, 1'b0, 1'b0},
    '{4'h4, CLH_GATE_TRI, 1'b1, 1'b1}, '{4'h5, CLH_GATE_TRI, 1'b1, 1'b1},
    '{4'h6, CLH_GATE_HS, 1'b1, 1'b1}, '{4'h7, CLH_GATE_LS, 1'b1, 1'b1},
    '{4'h8, CLH_GATE_RUN, 1'b1, 1'b0}, '{4'h9, CLH_GATE_RUN, 1'b1, 1'b0},
    '{4'hA, CLH_GATE_RUN, 1'b1, 1'b0}, '{4'hB, CLH_GATE_RUN, 1'b1, 1'b0},
    '{4'hC, CLH_GATE_RUN, 1'b1, 1'b0}, '{4'hD, CLH_GATE_RUN, 1'b1, 1'b0},
    '{4'hE, CLH_GATE_RUN, 1'b1, 1'b0}, '{4'hF, CLH_GATE_RUN, 1'b1, 1'b0}};
  localparam logic [31:0] LIM_CODE [3] = '{32'h1, 32'h4, 32'h7};
  localparam logic [31:0] LIM_N [3]    = '{32'h2, 32'h7, 32'h14};
  // Threshold in 0.1 mA: enable, code, sensed current, expected lock
  localparam logic [31:0] NM_ROWS [5] = '{32'h1_0_01D3_1, 32'h1_0_01D5_0,
    32'h1_7_1869_1, 32'h1_7_186B_0, 32'h0_7_0100_0};

  logic          sys_clk_in;
  logic          rst_in;
  clh_apb_req_s  apb;
  clh_apb_rsp_s  rsp;
  clh_gate_e     gate;
  logic          fault_n;
  logic          retry_run;
  logic          nm_lock;
  logic          irq;
  logic          trip;
  logic          driven;
  logic [15:0]   current;
  logic          jam;
  logic          drive;
  logic [15:0]   load;
  logic [31:0]   r;
  logic          e;
  int            n;
  int            cnt;
  int            fail_count;
  int            comparisons;
  int            cycles;

  clh_top #(.WAIT_W(16)) i_clh_top (
    .sys_clk_in              (sys_clk_in),
    .rst_in                  (rst_in),
    .apb_in                  (apb),
    .current_limit_trip_in   (trip),
    .motor_driven_in         (driven),
    .phase_current_in        (current),
    .apb_out                 (rsp),
    .gate_mode_out           (gate),
    .fault_indicator_low_out (fault_n),
    .retry_run_out           (retry_run),
    .no_motor_lock_out       (nm_lock),
    .irq_out                 (irq)
  );

  clh_power_stage i_clh_power_stage (
    .jam_in       (jam),
    .drive_in     (drive),
    .load_in      (load),
    .gate_mode_in (gate),
    .trip_out     (trip),
    .driven_out   (driven),
    .current_out  (current)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded so a hung design still reaches the report
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_gate(input clh_gate_e got, input clh_gate_e exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask

  // One idle cycle first, so a release never meets the next setup
  task automatic apb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk_in);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 50);
    chk_word({31'h0, rsp.pready}, 32'h1);
    r = rsp.prdata;
    e = rsp.pslverr;
    apb <= '0;
  endtask

  initial
  begin
    rst_in = 1'b1;
    apb = '0;
    jam = 1'b0;
    drive = 1'b0;
    load = 16'hFFFF;
    fail_count = 0;
    comparisons = 0;
    cyc(20);
    rst_in <= 1'b0;
    cyc(1);
    chk_gate(gate, CLH_GATE_RUN);
    chk_word({31'h0, fault_n}, 32'h1);
    apb_xfer(1'b0, CFG_OFS, 32'h0);
    chk_word(r, 32'h0);
    apb_xfer(1'b0, WAIT_OFS, 32'h0);
    chk_word(r, 32'h3E8);
    apb_xfer(1'b0, 8'h1C, 32'h0);
    chk_word({r[30:0], e}, 32'h1);
    apb_xfer(1'b1, CFG_OFS, 32'hFFFF_FFFF);
    apb_xfer(1'b0, CFG_OFS, 32'h0);
    chk_word(r, 32'h103F_F007);
    apb_xfer(1'b1, WAIT_OFS, 32'h2);
    for (int i = 0; i < 16; i++)
    begin
      apb_xfer(1'b1, CFG_OFS, 32'(ROWS[i].mode) << MODE_LSB);
      jam <= 1'b1;
      cyc(6);
      chk_gate(gate, ROWS[i].gate);
      chk_word({31'h0, fault_n}, {31'h0, ROWS[i].pin});
      if (!ROWS[i].retry)
      begin
        apb_xfer(1'b0, STAT_OFS, 32'h0);
        chk_word(r & 32'h3, ROWS[i].pin ? 32'h0 : 32'h3);
      end
      jam <= 1'b0;
      n = 0;
      while (retry_run !== 1'b1 && n < (ROWS[i].retry ? 1000 : 10))
      begin
        cyc(1);
        n++;
      end
      chk_word({30'h0, retry_run, 1'(n > 380)},
               {30'h0, ROWS[i].retry, ROWS[i].retry});
      apb_xfer(1'b1, CTRL_OFS, 32'h1);
      apb_xfer(1'b1, CLR_OFS, 32'hF);
      cyc(2);
      chk_gate(gate, CLH_GATE_RUN);
    end
    // Four clean retries leave the count at four, run state
    apb_xfer(1'b0, STATE_OFS, 32'h0);
    chk_word(r, 32'h0000_0810);
    // Only a released latch clears the count
    apb_xfer(1'b1, CFG_OFS, 32'h0);
    jam <= 1'b1;
    cyc(6);
    jam <= 1'b0;
    chk_word({31'h0, fault_n}, 32'h0);
    apb_xfer(1'b1, CTRL_OFS, 32'h1);
    apb_xfer(1'b0, STATE_OFS, 32'h0);
    chk_word(r, 32'h0);
    // Rotor stays jammed, so every rerun trips again
    for (int k = 0; k < 3; k++)
    begin
      apb_xfer(1'b1, CFG_OFS, (32'h4 << MODE_LSB) | LIM_CODE[k]);
      jam <= 1'b1;
      n = 0;
      cnt = 0;
      while (fault_n !== 1'b0 && n < 15000)
      begin
        cyc(1);
        n++;
        if (retry_run === 1'b1)
          cnt++;
      end
      chk_word(32'(cnt), LIM_N[k]);
      chk_word({31'h0, fault_n}, 32'h0);
      jam <= 1'b0;
      apb_xfer(1'b1, CTRL_OFS, 32'h1);
      apb_xfer(1'b1, CLR_OFS, 32'hF);
    end
    // A 1 us filter is 200 cycles here
    apb_xfer(1'b1, CFG_OFS, 32'h1 << FILT_LSB);
    jam <= 1'b1;
    cyc(100);
    jam <= 1'b0;
    cyc(300);
    chk_gate(gate, CLH_GATE_RUN);
    jam <= 1'b1;
    cyc(150);
    chk_gate(gate, CLH_GATE_RUN);
    cyc(100);
    chk_gate(gate, CLH_GATE_TRI);
    jam <= 1'b0;
    apb_xfer(1'b1, IEN_OFS, 32'h0);
    cyc(2);
    chk_word({31'h0, irq}, 32'h0);
    apb_xfer(1'b1, IEN_OFS, 32'h2);
    cyc(2);
    chk_word({31'h0, irq}, 32'h1);
    apb_xfer(1'b1, CLR_OFS, 32'h2);
    cyc(2);
    chk_word({30'h0, irq, fault_n}, 32'h0);
    rst_in <= 1'b1;
    cyc(3);
    chk_word({30'h0, gate == CLH_GATE_RUN, fault_n}, 32'h3);
    rst_in <= 1'b0;
    drive <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      apb_xfer(1'b1, CFG_OFS, (32'(NM_ROWS[k][24]) << NM_EN_BIT) |
               (32'(NM_ROWS[k][22:20]) << THR_LSB) | (32'h8 << MODE_LSB));
      load <= NM_ROWS[k][19:4];
      cyc(1600);
      chk_word({31'h0, nm_lock}, {31'h0, NM_ROWS[k][0]});
      load <= 16'hFFFF;
      cyc(1600);
    end
    final_report();
  end
endmodule
`default_nettype wire
